// *** design/otd_core.sv ***
// instruction sequencer: fetch, operand formats, execute of the decode tail
`timescale 1ns/10ps

// Notes on behaviour
// RULE1: copy_index_to_acc copies index, flags untouched
// RULE2: wait clears mask, halts until interrupt
// RULE3: high nibble selects form, low nibble operation
// RULE4: bit branch fetches address then offset
// RULE5: full_address_form fetches high then low byte
// RULE6: long offset added to index register
// RULE7: short unsigned offset added to index
// RULE8: plain_indexed_form uses index, no operand
// RULE9: relative branch adds signed offset when taken
// RULE10: blank opcodes run as one-byte no-ops, flagged
module otd_core (
  // clock, reset, enable
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // program/data memory
  output logic [15:0]            mem_addr_o,
  output logic                   mem_rd_o,
  output logic                   mem_wr_o,
  output logic [7:0]             mem_wdata_o,
  input  wire logic [7:0]        mem_rdata_i,
  // interrupt pin, active low
  input  wire logic              irq_n_i,
  // cpu state
  output logic [7:0]             acc_o,
  output logic [7:0]             idx_o,
  output logic [15:0]            pc_o,
  output logic [4:0]             condition_flags_o,
  output logic                   halted_o,
  output logic [7:0]             opcode_o,
  output logic                   illegal_op_o,
  output logic                   foreign_op_o
);

  otd_pkg::otd_state_t state, next_state;
  otd_pkg::otd_mode_t  dec_mode, mode_q;
  otd_pkg::otd_cls_t   dec_cls, cls_q, cur_cls;
  logic [1:0]  dec_len;
  logic [15:0] pc, next_pc, ea, next_ea, ea_now, next_addr;
  logic [7:0]  acc, next_acc, idx, next_idx, opc, next_opc, b1, next_b1;
  logic [7:0]  rel, next_rel, next_wdata, m_val, alu_a, res;
  logic [4:0]  flg, next_flg;
  logic [3:0]  row;
  logic        busy, next_rd, next_wr, next_halt, next_ill, next_frn;
  logic        ea_go, m_go, done, br_take, bit_val;
  logic        irq_s1, irq_s2;
  logic [8:0]  wide;

  otd_mode_decode u_dec (
    .opc_i  (mem_rdata_i),
    .mode_o (dec_mode),
    .cls_o  (dec_cls),
    .len_o  (dec_len)
  );

  // outputs straight from flops
  assign acc_o             = acc;
  assign idx_o             = idx;
  assign pc_o              = pc;
  assign condition_flags_o = flg;
  assign opcode_o          = opc;

  // operation row and class of the instruction in hand
  assign row     = (state == otd_pkg::ST_OPCODE) ? mem_rdata_i[3:0] : opc[3:0];
  assign cur_cls = (state == otd_pkg::ST_OPCODE) ? dec_cls : cls_q;

  // RULE9: branch condition pairs, odd row inverts
  always_comb begin
    unique case (opc[3:1])
      3'h0: br_take = 1'b1;
      3'h1: br_take = ~(flg[otd_pkg::FLG_C] | flg[otd_pkg::FLG_Z]);
      3'h2: br_take = ~flg[otd_pkg::FLG_C];
      3'h3: br_take = ~flg[otd_pkg::FLG_Z];
      3'h4: br_take = ~flg[otd_pkg::FLG_H];
      3'h5: br_take = ~flg[otd_pkg::FLG_N];
      3'h6: br_take = ~flg[otd_pkg::FLG_I];
      default: br_take = ~irq_s2;
    endcase
    br_take = br_take ^ opc[0];
  end

  // sequencer and execute
  always_comb begin
    next_state = state;
    next_pc    = pc;
    next_acc   = acc;
    next_idx   = idx;
    next_flg   = flg;
    next_opc   = opc;
    next_b1    = b1;
    next_rel   = rel;
    next_ea    = ea;
    next_addr  = mem_addr_o;
    next_wdata = mem_wdata_o;
    next_rd    = 1'b0;
    next_wr    = 1'b0;
    next_halt  = halted_o;
    next_ill   = 1'b0;
    next_frn   = 1'b0;
    ea_go      = 1'b0;
    ea_now     = ea;
    m_go       = 1'b0;
    m_val      = mem_rdata_i;
    done       = 1'b0;
    bit_val    = 1'b0;
    alu_a      = acc;
    res        = 8'h00;
    wide       = 9'h000;
    if (!busy) begin
      unique case (state)
        otd_pkg::ST_FETCH: begin
          next_addr  = pc;
          next_rd    = 1'b1;
          next_state = otd_pkg::ST_OPCODE;
        end
        otd_pkg::ST_OPCODE: begin
          next_opc = mem_rdata_i;
          next_pc  = pc + 16'h0001;
          if (dec_cls == otd_pkg::CLS_ILLEGAL) begin
            // RULE10: one-byte no-op with flag pulse
            next_ill = 1'b1;
            done     = 1'b1;
          end else if (dec_cls == otd_pkg::CLS_FOREIGN) begin
            next_frn = 1'b1;
            next_pc  = pc + {14'h0000, dec_len};
            done     = 1'b1;
          end else if (dec_cls == otd_pkg::CLS_WAIT) begin
            // RULE2: clear mask and stop
            next_flg[otd_pkg::FLG_I] = 1'b0;
            next_halt  = 1'b1;
            next_state = otd_pkg::ST_HALT;
          end else if (dec_cls == otd_pkg::CLS_INH) begin
            done = 1'b1;
            unique case (mem_rdata_i)
              // RULE1: index into accumulator only
              otd_pkg::OPC_COPY_IDX_ACC: next_acc = idx;
              otd_pkg::OPC_TAX: next_idx = acc;
              otd_pkg::OPC_CLC: next_flg[otd_pkg::FLG_C] = 1'b0;
              otd_pkg::OPC_SEC: next_flg[otd_pkg::FLG_C] = 1'b1;
              otd_pkg::OPC_CLI: next_flg[otd_pkg::FLG_I] = 1'b0;
              otd_pkg::OPC_SEI: next_flg[otd_pkg::FLG_I] = 1'b1;
              default: ;
            endcase
          end else if (dec_mode == otd_pkg::MODE_PLAIN_IDX) begin
            // RULE8: index is the address
            ea_go  = 1'b1;
            ea_now = {8'h00, idx};
          end else begin
            next_addr  = pc + 16'h0001;
            next_rd    = 1'b1;
            next_state = otd_pkg::ST_BYTE1;
          end
        end
        otd_pkg::ST_BYTE1: begin
          next_b1 = mem_rdata_i;
          next_pc = pc + 16'h0001;
          unique case (mode_q)
            otd_pkg::MODE_LITERAL: m_go = 1'b1;
            otd_pkg::MODE_DIRECT: begin
              ea_go  = 1'b1;
              ea_now = {8'h00, mem_rdata_i};
            end
            otd_pkg::MODE_SHORT_OFS: begin
              // RULE7: unsigned byte plus index
              ea_go  = 1'b1;
              ea_now = {8'h00, mem_rdata_i} + {8'h00, idx};
            end
            otd_pkg::MODE_RELATIVE: begin
              // RULE9: signed displacement on taken branch
              if (br_take) next_pc = pc + 16'h0001 + {{8{mem_rdata_i[7]}}, mem_rdata_i};
              done = 1'b1;
            end
            default: begin
              next_addr  = pc + 16'h0001;
              next_rd    = 1'b1;
              next_state = otd_pkg::ST_BYTE2;
            end
          endcase
        end
        otd_pkg::ST_BYTE2: begin
          next_pc = pc + 16'h0001;
          ea_go   = 1'b1;
          unique case (mode_q)
            // RULE5: high byte then low byte
            otd_pkg::MODE_FULL_ADDR: ea_now = {b1, mem_rdata_i};
            // RULE6: 16-bit offset plus index
            otd_pkg::MODE_LONG_OFS: ea_now = {b1, mem_rdata_i} + {8'h00, idx};
            default: begin
              // RULE4: direct address then branch offset
              next_rel = mem_rdata_i;
              ea_now   = {8'h00, b1};
            end
          endcase
        end
        otd_pkg::ST_DATA: begin
          if (cls_q == otd_pkg::CLS_BIT_BRANCH) begin
            // RULE4: branch on selected bit, bit into carry
            bit_val = mem_rdata_i[opc[3:1]];
            next_flg[otd_pkg::FLG_C] = bit_val;
            if (bit_val ^ opc[0]) next_pc = pc + {{8{rel[7]}}, rel};
            done = 1'b1;
          end else begin
            m_go = 1'b1;
          end
        end
        otd_pkg::ST_HALT: begin
          // RULE2: resume on interrupt pin low
          if (!irq_s2) begin
            next_halt  = 1'b0;
            next_state = otd_pkg::ST_FETCH;
          end
        end
        default: next_state = otd_pkg::ST_FETCH;
      endcase

      // effective address ready: store, jump or read operand
      if (ea_go) begin
        next_ea = ea_now;
        if (cur_cls == otd_pkg::CLS_ALU &&
            (row == otd_pkg::ROW_STA || row == otd_pkg::ROW_STX)) begin
          res        = (row == otd_pkg::ROW_STA) ? acc : idx;
          next_addr  = ea_now;
          next_wdata = res;
          next_wr    = 1'b1;
          next_flg[otd_pkg::FLG_N] = res[7];
          next_flg[otd_pkg::FLG_Z] = (res == 8'h00);
          next_state = otd_pkg::ST_FETCH;
        end else if (cur_cls == otd_pkg::CLS_ALU && row == otd_pkg::ROW_JMP) begin
          next_pc = ea_now;
          done    = 1'b1;
        end else begin
          next_addr  = ea_now;
          next_rd    = 1'b1;
          next_state = otd_pkg::ST_DATA;
        end
      end

      // RULE3: low nibble chooses the operation
      if (m_go) begin
        alu_a = (row == otd_pkg::ROW_CPX) ? idx : acc;
        unique case (row)
          otd_pkg::ROW_SUB, otd_pkg::ROW_CMP, otd_pkg::ROW_SBC, otd_pkg::ROW_CPX: begin
            wide = {1'b0, alu_a} - {1'b0, m_val} -
                   {8'h00, (row == otd_pkg::ROW_SBC) & flg[otd_pkg::FLG_C]};
            next_flg[otd_pkg::FLG_C] = wide[8];
          end
          otd_pkg::ROW_ADC, otd_pkg::ROW_ADD: begin
            wide = {1'b0, alu_a} + {1'b0, m_val} +
                   {8'h00, (row == otd_pkg::ROW_ADC) & flg[otd_pkg::FLG_C]};
            next_flg[otd_pkg::FLG_C] = wide[8];
            next_flg[otd_pkg::FLG_H] = (alu_a[3] & m_val[3]) | (m_val[3] & ~wide[3]) |
                                       (~wide[3] & alu_a[3]);
          end
          otd_pkg::ROW_AND, otd_pkg::ROW_BIT: wide = {1'b0, alu_a & m_val};
          otd_pkg::ROW_EOR: wide = {1'b0, alu_a ^ m_val};
          otd_pkg::ROW_ORA: wide = {1'b0, alu_a | m_val};
          default: wide = {1'b0, m_val};
        endcase
        res = wide[7:0];
        next_flg[otd_pkg::FLG_N] = res[7];
        next_flg[otd_pkg::FLG_Z] = (res == 8'h00);
        if (row == otd_pkg::ROW_LDX) next_idx = res;
        else if (row != otd_pkg::ROW_CMP && row != otd_pkg::ROW_CPX &&
                 row != otd_pkg::ROW_BIT) next_acc = res;
        done = 1'b1;
      end

      // overlap next opcode fetch with instruction end
      if (done) begin
        next_addr  = next_pc;
        next_rd    = 1'b1;
        next_state = otd_pkg::ST_OPCODE;
      end
    end
  end

  // interrupt pin synchroniser
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_s1 <= 1'b1;
      irq_s2 <= 1'b1;
    end else if (ce_i) begin
      irq_s1 <= irq_n_i;
      irq_s2 <= irq_s1;
    end
  end

  // sequencer state and read wait
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state    <= otd_pkg::ST_FETCH;
      busy     <= 1'b0;
      halted_o <= 1'b0;
    end else if (ce_i) begin
      state    <= next_state;
      busy     <= next_rd;
      halted_o <= next_halt;
    end
  end

  // cpu registers
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pc  <= otd_pkg::RESET_PC;
      acc <= 8'h00;
      idx <= 8'h00;
      flg <= otd_pkg::FLG_RESET;
    end else if (ce_i) begin
      pc  <= next_pc;
      acc <= next_acc;
      idx <= next_idx;
      flg <= next_flg;
    end
  end

  // instruction holding registers
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      opc    <= 8'h00;
      b1     <= 8'h00;
      rel    <= 8'h00;
      ea     <= 16'h0000;
      mode_q <= otd_pkg::MODE_INHERENT;
      cls_q  <= otd_pkg::CLS_ILLEGAL;
    end else if (ce_i) begin
      opc <= next_opc;
      b1  <= next_b1;
      rel <= next_rel;
      ea  <= next_ea;
      if (!busy && state == otd_pkg::ST_OPCODE) begin
        mode_q <= dec_mode;
        cls_q  <= dec_cls;
      end
    end
  end

  // memory strobes and status pulses
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mem_addr_o   <= 16'h0000;
      mem_rd_o     <= 1'b0;
      mem_wr_o     <= 1'b0;
      mem_wdata_o  <= 8'h00;
      illegal_op_o <= 1'b0;
      foreign_op_o <= 1'b0;
    end else if (ce_i) begin
      mem_addr_o   <= next_addr;
      mem_rd_o     <= next_rd;
      mem_wr_o     <= next_wr;
      mem_wdata_o  <= next_wdata;
      illegal_op_o <= next_ill;
      foreign_op_o <= next_frn;
    end
  end

endmodule

// *** include/otd_pkg.sv ***
// shared constants and types for the opcode decode tail
package otd_pkg;

  // widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // start address after reset (vector fetch is outside this block)
  localparam logic [15:0] RESET_PC = 16'h0000;

  // condition_flags bit positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_I = 3;
  localparam int FLG_H = 4;

  // condition_flags after reset: interrupt mask set
  localparam logic [4:0] FLG_RESET = 5'h08;

  // inherent_form opcodes handled here
  localparam logic [7:0] OPC_WAIT = 8'h8f;
  localparam logic [7:0] OPC_TAX  = 8'h97;
  localparam logic [7:0] OPC_CLC  = 8'h98;
  localparam logic [7:0] OPC_SEC  = 8'h99;
  localparam logic [7:0] OPC_CLI  = 8'h9a;
  localparam logic [7:0] OPC_SEI  = 8'h9b;
  localparam logic [7:0] OPC_NOP  = 8'h9d;
  localparam logic [7:0] OPC_COPY_IDX_ACC = 8'h9f;

  // register/memory operation rows (low nibble)
  localparam logic [3:0] ROW_SUB = 4'h0;
  localparam logic [3:0] ROW_CMP = 4'h1;
  localparam logic [3:0] ROW_SBC = 4'h2;
  localparam logic [3:0] ROW_CPX = 4'h3;
  localparam logic [3:0] ROW_AND = 4'h4;
  localparam logic [3:0] ROW_BIT = 4'h5;
  localparam logic [3:0] ROW_LDA = 4'h6;
  localparam logic [3:0] ROW_STA = 4'h7;
  localparam logic [3:0] ROW_EOR = 4'h8;
  localparam logic [3:0] ROW_ADC = 4'h9;
  localparam logic [3:0] ROW_ORA = 4'ha;
  localparam logic [3:0] ROW_ADD = 4'hb;
  localparam logic [3:0] ROW_JMP = 4'hc;
  localparam logic [3:0] ROW_JSR = 4'hd;
  localparam logic [3:0] ROW_LDX = 4'he;
  localparam logic [3:0] ROW_STX = 4'hf;

  // sequencer states
  typedef enum logic [2:0] {
    ST_FETCH, ST_OPCODE, ST_BYTE1, ST_BYTE2, ST_DATA, ST_HALT
  } otd_state_t;

  // addressing forms
  typedef enum logic [3:0] {
    MODE_INHERENT, MODE_LITERAL, MODE_DIRECT, MODE_FULL_ADDR, MODE_LONG_OFS,
    MODE_SHORT_OFS, MODE_PLAIN_IDX, MODE_RELATIVE, MODE_BIT_BRANCH
  } otd_mode_t;

  // instruction classes
  typedef enum logic [2:0] {
    CLS_ALU, CLS_BRANCH, CLS_BIT_BRANCH, CLS_INH, CLS_WAIT, CLS_FOREIGN, CLS_ILLEGAL
  } otd_cls_t;

endpackage

// *** design/otd_mode_decode.sv ***
// opcode to addressing form, class and length decode
`timescale 1ns/10ps

module otd_mode_decode (
  // opcode byte
  input  wire logic [7:0]        opc_i,
  // decode results
  output otd_pkg::otd_mode_t     mode_o,
  output otd_pkg::otd_cls_t      cls_o,
  output logic [1:0]             len_o
);

  logic [3:0] col;
  logic [3:0] row;

  assign col = opc_i[7:4];
  assign row = opc_i[3:0];

  // high nibble picks group and form, low nibble the operation
  always_comb begin
    mode_o = otd_pkg::MODE_INHERENT;
    cls_o  = otd_pkg::CLS_FOREIGN;
    len_o  = 2'h1;
    unique case (col)
      4'h0: begin
        mode_o = otd_pkg::MODE_BIT_BRANCH;
        cls_o  = otd_pkg::CLS_BIT_BRANCH;
        len_o  = 2'h3;
      end
      4'h1: len_o = 2'h2;
      4'h2: begin
        mode_o = otd_pkg::MODE_RELATIVE;
        cls_o  = otd_pkg::CLS_BRANCH;
        len_o  = 2'h2;
      end
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
        len_o = (col == 4'h3 || col == 4'h6) ? 2'h2 : 2'h1;
        if (row == 4'h1 || row == 4'h5 || row == 4'hb || row == 4'he ||
            (row == 4'h2 && opc_i != 8'h42)) begin
          cls_o = otd_pkg::CLS_ILLEGAL;
          len_o = 2'h1;
        end
      end
      4'h8: begin
        if (opc_i == otd_pkg::OPC_WAIT) cls_o = otd_pkg::CLS_WAIT;
        else if (!(row == 4'h0 || row == 4'h1 || row == 4'h3 || row == 4'he))
          cls_o = otd_pkg::CLS_ILLEGAL;
      end
      4'h9: begin
        if (row < 4'h7 || row == 4'he) cls_o = otd_pkg::CLS_ILLEGAL;
        else if (row != 4'hc) cls_o = otd_pkg::CLS_INH;
      end
      default: begin
        // register/memory columns a..f
        cls_o = (row == otd_pkg::ROW_JSR) ? otd_pkg::CLS_FOREIGN : otd_pkg::CLS_ALU;
        unique case (col)
          4'ha: begin
            mode_o = otd_pkg::MODE_LITERAL;
            len_o  = 2'h2;
            if (row == otd_pkg::ROW_STA || row == otd_pkg::ROW_JMP ||
                row == otd_pkg::ROW_STX)
              cls_o = otd_pkg::CLS_ILLEGAL;
          end
          4'hb: begin mode_o = otd_pkg::MODE_DIRECT;    len_o = 2'h2; end
          4'hc: begin mode_o = otd_pkg::MODE_FULL_ADDR; len_o = 2'h3; end
          4'hd: begin mode_o = otd_pkg::MODE_LONG_OFS;  len_o = 2'h3; end
          4'he: begin mode_o = otd_pkg::MODE_SHORT_OFS; len_o = 2'h2; end
          default: begin mode_o = otd_pkg::MODE_PLAIN_IDX; len_o = 2'h1; end
        endcase
        if (cls_o == otd_pkg::CLS_ILLEGAL) len_o = 2'h1;
      end
    endcase
  end

endmodule

// *** testbench/otd_mem_model.sv ***
// behavioural program and data memory feeding the decode tail core
`timescale 1ns/10ps

module otd_mem_model (
  // clock
  input  wire logic        clk_sys_i,
  // access request
  input  wire logic [15:0] mem_addr_i,
  input  wire logic        mem_rd_i,
  input  wire logic        mem_wr_i,
  input  wire logic [7:0]  mem_wdata_i,
  // read answer
  output logic [7:0]       mem_rdata_o
);
  logic [7:0] mem [0:65535];

  // empty memory reads as no-ops
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h9d;
    mem_rdata_o = 8'h00;
  end

  // sync ram: byte held one cycle, garbage between reads
  always @(posedge clk_sys_i) begin
    if (mem_rd_i) mem_rdata_o <= mem[mem_addr_i];
    else mem_rdata_o <= ~mem_rdata_o;
    if (mem_wr_i) mem[mem_addr_i] <= mem_wdata_i;
  end

  // preload one byte straight into the array, with or without reset
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    mem[a] = d;
  endtask
endmodule

// *** testbench/otd_core_chk.sv ***
// port-level assertions for the decode tail core
`timescale 1ns/10ps

module otd_core_chk (
  // clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  // memory side and interrupt pin
  input wire logic [15:0] mem_addr_o,
  input wire logic        mem_rd_o,
  input wire logic        mem_wr_o,
  input wire logic [7:0]  mem_rdata_i,
  input wire logic        irq_n_i,
  // cpu state
  input wire logic [7:0]  acc_o,
  input wire logic [7:0]  idx_o,
  input wire logic [4:0]  condition_flags_o,
  input wire logic        halted_o,
  input wire logic        illegal_op_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // a byte answered right after a read strobe
  sequence op_s(logic [7:0] op);
    mem_rd_o ##1 mem_rdata_i == op;
  endsequence

  // transfer and wait
  xfer_copy_a: assert property (op_s(8'h9f) |=>
    acc_o == $past(idx_o) && condition_flags_o == $past(condition_flags_o))
    else $error("index copy wrong");
  xfer_len_a: assert property (op_s(8'h9f) |=>
    mem_rd_o && mem_addr_o == $past(mem_addr_o, 2) + 16'h0001)
    else $error("index copy not two cycles");
  wait_halt_a: assert property (op_s(8'h8f) |=> halted_o &&
    !condition_flags_o[otd_pkg::FLG_I] &&
    (condition_flags_o & 5'h17) == ($past(condition_flags_o) & 5'h17))
    else $error("wait did not halt");
  halt_quiet_a: assert property (halted_o |-> !mem_rd_o && !mem_wr_o)
    else $error("bus active while halted");
  wake_bound_a: assert property (halted_o && !irq_n_i |-> ##[1:5] !halted_o)
    else $error("no wake on interrupt");

  // operand formats and blank opcode flag
  full_addr_a: assert property (op_s(8'hc6) ##2 1'b1 ##2 1'b1 |=>
    mem_rd_o && mem_addr_o == {$past(mem_rdata_i, 3), $past(mem_rdata_i)})
    else $error("full address wrong");
  long_ofs_a: assert property (op_s(8'hdb) ##2 1'b1 ##2 1'b1 |=> mem_rd_o &&
    mem_addr_o == {$past(mem_rdata_i, 3), $past(mem_rdata_i)} + {8'h00, idx_o})
    else $error("long offset address wrong");
  short_ofs_a: assert property (op_s(8'heb) ##2 1'b1 |=> mem_rd_o &&
    mem_addr_o == {8'h00, $past(mem_rdata_i)} + {8'h00, idx_o})
    else $error("short offset address wrong");
  plain_idx_a: assert property (op_s(8'hfb) |=>
    mem_rd_o && mem_addr_o == {8'h00, idx_o})
    else $error("plain index address wrong");
  blank_flag_a: assert property (op_s(8'h31) |-> ##[1:2] illegal_op_o)
    else $error("blank opcode not flagged");

  // main scenarios reached
  cover property (halted_o);
  cover property (illegal_op_o);
  cover property (mem_wr_o);
endmodule

// *** testbench/cpu_opcode_decode_tail_test.sv ***
// self-checking bench for the decode tail core
`timescale 1ns/10ps

module cpu_opcode_decode_tail_test;
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        irq_n_i   = 1'b1;
  logic        ce_i      = 1'b1;
  logic [7:0]  opcode_o;
  logic [15:0] mem_addr_o;
  logic        mem_rd_o;
  logic        mem_wr_o;
  logic [7:0]  mem_wdata_o;
  logic [7:0]  mem_rdata_i;
  logic [7:0]  acc_o;
  logic [7:0]  idx_o;
  logic [15:0] pc_o;
  logic [4:0]  condition_flags_o;
  logic        halted_o;
  logic        illegal_op_o;
  logic        foreign_op_o;
  logic        ill_seen;
  logic        frn_seen;
  int          err_total;
  int          check_count;

  // design and memory
  otd_core u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
    .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .irq_n_i(irq_n_i),
    .acc_o(acc_o), .idx_o(idx_o), .pc_o(pc_o), .condition_flags_o(condition_flags_o),
    .halted_o(halted_o), .opcode_o(opcode_o), .illegal_op_o(illegal_op_o),
    .foreign_op_o(foreign_op_o));
  otd_mem_model u_mem (.clk_sys_i(clk_sys_i), .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o),
    .mem_wr_i(mem_wr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

  // 25 MHz clock
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // remember flag pulses, cleared while reset is held
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      ill_seen <= 1'b0;
      frn_seen <= 1'b0;
    end else begin
      if (illegal_op_o === 1'b1) ill_seen <= 1'b1;
      if (foreign_op_o === 1'b1) frn_seen <= 1'b1;
    end
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // load a program at 0 under a 4-cycle reset
  task automatic start(input logic [7:0] prog[$]);
    rst_i = 1'b1;
    for (int i = 0; i < prog.size(); i++) u_mem.put(16'(i), prog[i]);
    repeat (4) @(posedge clk_sys_i);
    check(pc_o, otd_pkg::RESET_PC);
    check(16'(condition_flags_o), 16'(otd_pkg::FLG_RESET));
    #1 rst_i = 1'b0;
  endtask

  // bounded wait for the program counter
  task automatic run_to(input logic [15:0] stop);
    int n;
    n = 0;
    while (pc_o !== stop && n < 300) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    if (pc_o !== stop) begin
      err_total++;
      $display("[FAIL] %0t pc stuck before %h", $time, stop);
      finish_test();
    end
  endtask

  task automatic t_copy();
    start('{8'hae, 8'h5a, 8'h99, 8'h9f, 8'h9d});
    run_to(16'h0005);
    check(16'(acc_o), 16'h005a);
    check(16'(condition_flags_o), 16'h0009);
    check(16'(opcode_o), 16'(otd_pkg::OPC_NOP));
    check(mem_addr_o, 16'h0005);
    check(16'(mem_rd_o), 16'h0001);
    // enable low freezes every flop
    ce_i = 1'b0;
    repeat (6) @(posedge clk_sys_i);
    #1;
    check(pc_o, 16'h0005);
    check(16'(mem_rd_o), 16'h0001);
    ce_i = 1'b1;
  endtask

  task automatic t_forms();
    u_mem.put(16'h1234, 8'h11);
    u_mem.put(16'h0240, 8'h22);
    u_mem.put(16'h0060, 8'h44);
    u_mem.put(16'h0010, 8'h08);
    start('{8'hae, 8'h10, 8'hc6, 8'h12, 8'h34, 8'hdb, 8'h02, 8'h30, 8'heb, 8'h50,
            8'hfb, 8'he7, 8'h70, 8'h9d});
    run_to(16'h000e);
    check(16'(acc_o), 16'h007f);
    check(16'(condition_flags_o), 16'h0008);
    check(16'(u_mem.mem[16'h0080]), 16'h007f);
    check(16'(mem_wdata_o), 16'h007f);
  endtask

  task automatic t_branch();
    u_mem.put(16'h0050, 8'h01);
    start('{8'h20, 8'h03, 8'hae, 8'hee, 8'h9d, 8'h21, 8'h7f, 8'h20, 8'h04, 8'h20,
            8'h05, 8'hae, 8'hee, 8'h20, 8'hfa, 8'h9d, 8'h00, 8'h50, 8'h03, 8'hae,
            8'hee, 8'h9d, 8'h01, 8'h50, 8'h02, 8'ha6, 8'h5c, 8'h9d});
    run_to(16'h001c);
    check(16'(idx_o), 16'h0000);
    check(16'(acc_o), 16'h005c);
    check(16'(condition_flags_o), 16'h0009);
  endtask

  task automatic t_wait();
    int n;
    start('{8'h8f, 8'ha6, 8'h3c, 8'h9d});
    n = 0;
    while (halted_o !== 1'b1 && n < 20) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    if (halted_o !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t core never halted", $time);
      finish_test();
    end
    repeat (8) @(posedge clk_sys_i);
    #1;
    check(16'(halted_o), 16'h0001);
    check(16'(condition_flags_o), 16'h0000);
    irq_n_i = 1'b0;
    run_to(16'h0004);
    irq_n_i = 1'b1;
    check(16'(acc_o), 16'h003c);
    check(16'(halted_o), 16'h0000);
  endtask

  task automatic t_blank();
    u_mem.put(16'h0070, 8'h0f);
    start('{8'h31, 8'h42, 8'ha6, 8'h21, 8'hb0, 8'h70, 8'h9d});
    run_to(16'h0007);
    check(16'(acc_o), 16'h0012);
    check(16'(condition_flags_o), 16'h0008);
    check(16'(ill_seen), 16'h0001);
    check(16'(frn_seen), 16'h0001);
  endtask

  // main sequence
  initial begin
    err_total = 0;
    check_count = 0;
    @(posedge clk_sys_i);
    #1;
    t_copy();
    t_forms();
    t_branch();
    t_wait();
    t_blank();
    finish_test();
  end
endmodule

bind otd_core otd_core_chk u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
  .mem_rdata_i(mem_rdata_i), .irq_n_i(irq_n_i), .acc_o(acc_o), .idx_o(idx_o),
  .condition_flags_o(condition_flags_o), .halted_o(halted_o),
  .illegal_op_o(illegal_op_o));
